/* File: dv/metering_accum_config_regs_tb.sv */
// Self-checking testbench for the accumulation configuration registers
`timescale 1ns/100ps
`default_nettype none
module metering_accum_config_regs_tb;
  import mac_pkg::*;
  localparam int W  = 24;
  localparam int PW = 32;
  logic            REF_CLK, SRST, REG_WR, REG_RD, SAMPLE_VALID, ZX_PRESENT;
  logic [11:0]     REG_ADDR;
  logic [15:0]     REG_WDATA, REG_RDATA, MEAS_PERIOD, LINE_PERIOD;
  logic            REG_RVALID, EFF_VALID, LINE_IS_60HZ, PWR_VALID, PULSE_VALID;
  logic [W-1:0]    VA_IN, VB_IN, VC_IN, IA_IN, IB_IN, IC_IN;
  logic [W+1:0]    VA_EFF, VB_EFF, VC_EFF, IB_EFF;
  logic [12*PW-1:0] PWR_IN;
  logic [4*PW+11:0] PULSE_SUM;
  logic [3:0]      PWR_REACTIVE, OC_RAW, OC_ENABLE, OC_FLAG;
  int              fails, cmp_count;

  mac_accum_cfg #(.W(W), .PW(PW)) mac_accum_cfg_i (
    .REF_CLK(REF_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .SAMPLE_VALID(SAMPLE_VALID), .VA_IN(VA_IN),
    .VB_IN(VB_IN), .VC_IN(VC_IN), .IA_IN(IA_IN), .IB_IN(IB_IN),
    .IC_IN(IC_IN), .VA_EFF(VA_EFF), .VB_EFF(VB_EFF), .VC_EFF(VC_EFF),
    .IB_EFF(IB_EFF), .EFF_VALID(EFF_VALID), .ZX_PRESENT(ZX_PRESENT),
    .MEAS_PERIOD(MEAS_PERIOD), .LINE_PERIOD(LINE_PERIOD),
    .LINE_IS_60HZ(LINE_IS_60HZ), .PWR_VALID(PWR_VALID), .PWR_IN(PWR_IN),
    .PWR_REACTIVE(PWR_REACTIVE), .PULSE_SUM(PULSE_SUM),
    .PULSE_VALID(PULSE_VALID), .OC_RAW(OC_RAW), .OC_ENABLE(OC_ENABLE),
    .OC_FLAG(OC_FLAG));

  // 200 MHz clock
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Bounded wait on a one-cycle answer pulse; a hang ends the run
  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    while (n < 8 && !((sel == 0 && REG_RVALID === 1'b1) ||
           (sel == 1 && EFF_VALID === 1'b1) ||
           (sel == 2 && PULSE_VALID === 1'b1))) begin
      @(posedge REF_CLK);
      #1;
      n++;
    end
    if (n == 8) begin
      fails++;
      $display("unexpected answer pulse %0d: expected 1, seen 0", sel);
      conclude();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge REF_CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge REF_CLK);
    REG_WR    <= 1'b0;
    // Registered config outputs follow one cycle after the write lands
    repeat (2) @(posedge REF_CLK);
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge REF_CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge REF_CLK);
    REG_RD   <= 1'b0;
    #1;
    wait_hi(0);
    chk("REG_RDATA", 64'(e), 64'(REG_RDATA));
  endtask

  function automatic longint fmode(input int md, input longint x);
    case (md)
      0: return x;
      1: return (x < 0) ? -x : x;
      2: return (x > 0) ? x : 0;
      default: return (x < 0) ? x : 0;
    endcase
  endfunction

  // Reset values, reserved bits and an unmapped place
  task automatic t_regs();
    rd(MAC_ADDR_PULSE_SEL, 16'h0000);
    rd(MAC_ADDR_ACCUM, 16'h0000);
    rd(MAC_ADDR_OC, 16'hf000);
    chk("OC_ENABLE", 64'(4'hf), 64'(OC_ENABLE));
    wr(MAC_ADDR_PULSE_SEL, 16'hffff);
    rd(MAC_ADDR_PULSE_SEL, 16'h0fff);
    wr(MAC_ADDR_ACCUM, 16'hffff);
    rd(MAC_ADDR_ACCUM, 16'h01ff);
    rd(12'h4a5, 16'h0000);
  endtask

  // Each enable bit alone and one mixed set, gating the raw detect
  task automatic t_oc();
    logic [3:0] e;
    OC_RAW <= 4'hf;
    for (int i = 0; i < 5; i++) begin
      e = (i < 4) ? 4'(1 << i) : 4'h5;
      wr(MAC_ADDR_OC, {e, 12'hfff});
      rd(MAC_ADDR_OC, {e, 12'h000});
      chk("OC_ENABLE", 64'(e), 64'(OC_ENABLE));
      chk("OC_FLAG", 64'(e), 64'(OC_FLAG));
    end
  endtask

  // Default period from the frequency bit, measured one with crossings
  task automatic t_period();
    ZX_PRESENT  <= 1'b0;
    MEAS_PERIOD <= 16'h1234;
    wr(MAC_ADDR_ACCUM, 16'h0000);
    chk("LINE_PERIOD", 64'(16'(8000 / 50)), 64'(LINE_PERIOD));
    chk("LINE_IS_60HZ", 64'(1'b0), 64'(LINE_IS_60HZ));
    wr(MAC_ADDR_ACCUM, 16'h0100);
    chk("LINE_PERIOD", 64'(16'(8000 / 60)), 64'(LINE_PERIOD));
    chk("LINE_IS_60HZ", 64'(1'b1), 64'(LINE_IS_60HZ));
    ZX_PRESENT <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    #1;
    chk("LINE_PERIOD", 64'(16'h1234), 64'(LINE_PERIOD));
  endtask

  // Wiring codes 000 to 100 (unused codes 101 to 111 not driven), with current derivation toggled alongside
  task automatic t_wiring();
    int va, vb, vc, ea, eb, ec, ib;
    va = 1000;
    vb = -300;
    vc = 250;
    VA_IN <= 24'(va);
    VB_IN <= 24'(vb);
    VC_IN <= 24'(vc);
    IA_IN <= 24'(40);
    IB_IN <= 24'(7);
    IC_IN <= 24'(-15);
    for (int c = 0; c < 5; c++) begin
      wr(MAC_ADDR_ACCUM, 16'((c << 4) | ((c & 1) << 7)));
      ea = (c == 4) ? va - vb : va;
      eb = (c == 1 || c == 4) ? va - vc : (c == 2) ? -(va + vc) :
           (c == 3) ? -va : vb;
      ec = (c == 4) ? vc - vb : vc;
      ib = (c & 1) ? -40 + 15 : 7;
      @(posedge REF_CLK);
      SAMPLE_VALID <= 1'b1;
      @(posedge REF_CLK);
      SAMPLE_VALID <= 1'b0;
      #1;
      wait_hi(1);
      chk("VA_EFF", 64'(ea[25:0]), 64'(VA_EFF));
      chk("VB_EFF", 64'(eb[25:0]), 64'(VB_EFF));
      chk("VC_EFF", 64'(ec[25:0]), 64'(VC_EFF));
      chk("IB_EFF", 64'(ib[25:0]), 64'(IB_EFF));
    end
  endtask

  // Phase include fields against all four modes per energy kind
  task automatic t_power();
    longint pw[3];
    longint e;
    int md;
    pw = '{5, -7, 11};
    PWR_REACTIVE <= 4'b0011;
    for (int k = 0; k < 12; k++) begin
      PWR_IN[k*PW +: PW] <= 32'(pw[k % 3]);
    end
    wr(MAC_ADDR_PULSE_SEL, 16'h08ff);
    for (int m = 0; m < 4; m++) begin
      wr(MAC_ADDR_ACCUM, 16'(((3 - m) << 2) | m));
      @(posedge REF_CLK);
      PWR_VALID <= 1'b1;
      @(posedge REF_CLK);
      PWR_VALID <= 1'b0;
      #1;
      wait_hi(2);
      for (int k = 0; k < 4; k++) begin
        md = ((4'b0011 >> k) & 1) ? 3 - m : m;
        e = 0;
        for (int p = 0; p < 3; p++) begin
          if ((12'h8ff >> (k * 3 + p)) & 1) e += fmode(md, pw[p]);
        end
        chk("PULSE_SUM", 64'(e[34:0]), 64'(PULSE_SUM[k*35 +: 35]));
      end
    end
  endtask

  // Reset, then the scenarios in turn
  initial begin
    fails = 0;
    cmp_count = 0;
    SRST = 1'b1;
    {REG_WR, REG_RD, SAMPLE_VALID, ZX_PRESENT, PWR_VALID} = 5'h00;
    REG_ADDR = 12'h000;
    REG_WDATA = 16'h0000;
    MEAS_PERIOD = 16'h0000;
    {VA_IN, VB_IN, VC_IN, IA_IN, IB_IN, IC_IN} = '0;
    PWR_IN = '0;
    PWR_REACTIVE = 4'h0;
    OC_RAW = 4'h0;
    repeat (6) @(posedge REF_CLK);
    SRST <= 1'b0;
    t_regs();
    t_oc();
    t_period();
    t_wiring();
    t_power();
    conclude();
  end
endmodule
`default_nettype wire

/* File: rtl/mac_accum_cfg.sv */
// Accumulation configuration registers and the datapath steering they drive
//
// How it works
// [RULE1] Pulse 4 include field bits 11:9; bit2 phase C, bit1 B, bit0 A.
// [RULE2] Pulse 3,2,1 include fields at 8:6, 5:3, 2:0; reset zero, read/write.
// [RULE3] Frequency bit clear means 50 Hz, set means 60 Hz line.
// [RULE4] Without zero crossings the line period defaults from the frequency bit.
// [RULE5] Derive bit set: phase B current becomes minus phase A minus phase C.
// [RULE6] Wiring 000 measured wye; 010 VB=-(VA+VC); 011 VB=-VA.
// [RULE7] Wiring 100 three-wire delta: VA-VB, VA-VC, VC-VB.
// [RULE8] Wiring 001 replaces only phase B voltage with VA-VC.
// [RULE9] Reactive mode bits 3:2: signed, absolute, positive-only, negative-only.
// [RULE10] Active mode bits 1:0 use the same four-mode encoding.
// [RULE11] Overcurrent enables reset to all ones; any combination allowed.
// [RULE12] Overcurrent bit 12 phase A, 13 B, 14 C, 15 neutral.
// [RULE13] Energy type is chosen elsewhere; include fields only pick phases.
`timescale 1ns/100ps
`default_nettype none
module mac_accum_cfg
  import mac_pkg::*;
#(
  parameter int W    = 24,  // Waveform sample width
  parameter int PW   = 32,  // Power sample width
  parameter int PERW = 16,  // Line period width, in sample counts
  parameter int RATE = MAC_SAMPLE_RATE_HZ
) (
  input  wire logic              REF_CLK,
  input  wire logic              SRST,
  input  wire logic [11:0]       REG_ADDR,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic [15:0]       REG_WDATA,
  output logic      [15:0]       REG_RDATA,
  output logic                   REG_RVALID,
  input  wire logic              SAMPLE_VALID,
  input  wire logic [W-1:0]      VA_IN,
  input  wire logic [W-1:0]      VB_IN,
  input  wire logic [W-1:0]      VC_IN,
  input  wire logic [W-1:0]      IA_IN,
  input  wire logic [W-1:0]      IB_IN,
  input  wire logic [W-1:0]      IC_IN,
  output logic      [W+1:0]      VA_EFF,
  output logic      [W+1:0]      VB_EFF,
  output logic      [W+1:0]      VC_EFF,
  output logic      [W+1:0]      IB_EFF,
  output logic                   EFF_VALID,
  input  wire logic              ZX_PRESENT,
  input  wire logic [PERW-1:0]   MEAS_PERIOD,
  output logic      [PERW-1:0]   LINE_PERIOD,
  output logic                   LINE_IS_60HZ,
  input  wire logic              PWR_VALID,
  input  wire logic [12*PW-1:0]  PWR_IN,
  input  wire logic [3:0]        PWR_REACTIVE,
  output logic      [4*PW+11:0]  PULSE_SUM,
  output logic                   PULSE_VALID,
  input  wire logic [3:0]        OC_RAW,
  output logic      [3:0]        OC_ENABLE,
  output logic      [3:0]        OC_FLAG
);

  localparam int SW = PW + 3;  // Three phase terms, each one bit wider
  localparam logic [PERW-1:0] PER_50 = PERW'(RATE / MAC_LINE_HZ_50);
  localparam logic [PERW-1:0] PER_60 = PERW'(RATE / MAC_LINE_HZ_60);

  logic [MAC_PSEL_W-1:0] psel_reg,  psel_next;
  logic [MAC_ACC_W-1:0]  acc_reg,   acc_next;
  logic [MAC_OC_W-1:0]   oc_reg,    oc_next;
  logic [15:0]           rdata_reg, rdata_next;
  logic                  rvalid_reg, rvalid_next;
  logic [W+1:0]          va_reg, va_next, vb_reg, vb_next;
  logic [W+1:0]          vc_reg, vc_next, ib_reg, ib_next;
  logic                  effv_reg, effv_next;
  logic [PERW-1:0]       per_reg, per_next;
  logic                  f60_reg, f60_next;
  logic [4*SW-1:0]       sum_reg, sum_next;
  logic                  pv_reg, pv_next;
  logic [3:0]            ocf_reg, ocf_next;
  logic signed [W+1:0]   ea, eb, ec, ei_a, ei_c;
  mac_wire_t             wire_sel;
  mac_acc_t              var_mode, watt_mode;

  // Register read image; reserved and unmapped bits read as zero
  function automatic logic [15:0] mac_read(input logic [11:0] a);
    logic [15:0] d;
    d = 16'h0000;
    unique case (a)
      MAC_ADDR_PULSE_SEL: d = {4'h0, psel_reg};
      MAC_ADDR_ACCUM:     d = {7'h00, acc_reg};
      MAC_ADDR_OC:        d = {oc_reg, 12'h000};
      default:            d = 16'h0000;
    endcase
    return d;
  endfunction

  // Sign extension of a waveform sample to the datapath width
  function automatic logic signed [W+1:0] mac_ext(input logic [W-1:0] x);
    return signed'({{2{x[W-1]}}, x});
  endfunction

  // One phase power shaped by its accumulation mode
  function automatic logic signed [PW:0] mac_accum(
    input mac_acc_t m, input logic [PW-1:0] x);
    logic signed [PW:0] xe;
    xe = signed'({x[PW-1], x});
    unique case (m)
      MAC_ACC_SIGNED: return xe;
      MAC_ACC_ABS:    return (xe < 0) ? -xe : xe;
      MAC_ACC_POS:    return (xe > 0) ? xe : '0;
      MAC_ACC_NEG:    return (xe < 0) ? xe : '0;
    endcase
  endfunction

  assign wire_sel  = mac_wire_t'(acc_reg[MAC_ACC_WIRE_LSB +: 3]);
  assign var_mode  = mac_acc_t'(acc_reg[MAC_ACC_VAR_LSB +: 2]);
  assign watt_mode = mac_acc_t'(acc_reg[MAC_ACC_WATT_LSB +: 2]);
  assign ea   = mac_ext(VA_IN);
  assign eb   = mac_ext(VB_IN);
  assign ec   = mac_ext(VC_IN);
  assign ei_a = mac_ext(IA_IN);
  assign ei_c = mac_ext(IC_IN);

  // Host register port: writes land next edge, reads answer one cycle on
  always_comb begin
    psel_next   = psel_reg;
    acc_next    = acc_reg;
    oc_next     = oc_reg;
    rvalid_next = REG_RD;
    rdata_next  = REG_RD ? mac_read(REG_ADDR) : rdata_reg;
    if (REG_WR) begin
      unique case (REG_ADDR)
        MAC_ADDR_PULSE_SEL: psel_next = REG_WDATA[MAC_PSEL_W-1:0]; // [RULE2]
        MAC_ADDR_ACCUM:     acc_next  = REG_WDATA[MAC_ACC_W-1:0];
        MAC_ADDR_OC:        oc_next   = REG_WDATA[MAC_OC_LSB +: MAC_OC_W]; // [RULE11]
        default:            ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      psel_reg   <= MAC_PSEL_RST; // [RULE2]
      acc_reg    <= MAC_ACC_RST;
      oc_reg     <= MAC_OC_RST;   // [RULE11]
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      psel_reg   <= psel_next;
      acc_reg    <= acc_next;
      oc_reg     <= oc_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Waveform substitution; held between samples so consumers see stable data
  always_comb begin
    va_next   = va_reg;
    vb_next   = vb_reg;
    vc_next   = vc_reg;
    ib_next   = ib_reg;
    effv_next = SAMPLE_VALID;
    if (SAMPLE_VALID) begin
      va_next = ea;
      vb_next = eb;
      vc_next = ec;
      unique case (wire_sel)
        MAC_WIRE_DELTA_VB: vb_next = ea - ec;     // [RULE8]
        MAC_WIRE_NB_WYE:   vb_next = -(ea + ec);  // [RULE6]
        MAC_WIRE_NB_DELTA: vb_next = -ea;         // [RULE6]
        MAC_WIRE_DELTA3: begin
          va_next = ea - eb;                      // [RULE7]
          vb_next = ea - ec;                      // [RULE7]
          vc_next = ec - eb;                      // [RULE7]
        end
        default: ;  // Wye and unused codes keep measured voltages [RULE6]
      endcase
      // Lets a meter run with only two current sensors
      ib_next = acc_reg[MAC_ACC_ICONS_BIT] ? -(ei_a + ei_c) : mac_ext(IB_IN); // [RULE5]
    end
  end

  // Line period falls back to the nominal period of the chosen frequency
  always_comb begin
    f60_next = acc_reg[MAC_ACC_FREQ_BIT];  // [RULE3]
    if (ZX_PRESENT)
      per_next = MEAS_PERIOD;
    else
      per_next = f60_next ? PER_60 : PER_50; // [RULE4]
  end

  // Pulse sums: phase terms shaped by mode, then gated by include fields
  always_comb begin
    logic signed [PW:0]   term;
    logic signed [SW-1:0] acc;
    mac_acc_t             m;
    term    = '0;
    acc     = '0;
    m       = MAC_ACC_SIGNED;
    sum_next = sum_reg;
    pv_next  = PWR_VALID;
    if (PWR_VALID) begin
      for (int k = 0; k < 4; k++) begin
        // Energy type arrives already chosen; only its class matters [RULE13]
        m   = PWR_REACTIVE[k] ? var_mode : watt_mode; // [RULE9] [RULE10]
        acc = '0;
        for (int p = 0; p < 3; p++) begin
          term = mac_accum(m, PWR_IN[(k*3+p)*PW +: PW]);
          if (psel_reg[k*MAC_PSEL_FIELD_W + p]) // [RULE1] [RULE2]
            acc = acc + signed'({{2{term[PW]}}, term});
        end
        sum_next[k*SW +: SW] = acc;
      end
    end
  end

  // Overcurrent gating: field bit 0 (reg bit 12) is phase A, bit 3 neutral
  always_comb begin
    ocf_next = OC_RAW & oc_reg; // [RULE12]
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      va_reg   <= '0;
      vb_reg   <= '0;
      vc_reg   <= '0;
      ib_reg   <= '0;
      effv_reg <= 1'b0;
      per_reg  <= '0;
      f60_reg  <= 1'b0;
      sum_reg  <= '0;
      pv_reg   <= 1'b0;
      ocf_reg  <= 4'h0;
    end else begin
      va_reg   <= va_next;
      vb_reg   <= vb_next;
      vc_reg   <= vc_next;
      ib_reg   <= ib_next;
      effv_reg <= effv_next;
      per_reg  <= per_next;
      f60_reg  <= f60_next;
      sum_reg  <= sum_next;
      pv_reg   <= pv_next;
      ocf_reg  <= ocf_next;
    end
  end

  assign REG_RDATA    = rdata_reg;
  assign REG_RVALID   = rvalid_reg;
  assign VA_EFF       = va_reg;
  assign VB_EFF       = vb_reg;
  assign VC_EFF       = vc_reg;
  assign IB_EFF       = ib_reg;
  assign EFF_VALID    = effv_reg;
  assign LINE_PERIOD  = per_reg;
  assign LINE_IS_60HZ = f60_reg;
  assign PULSE_SUM    = sum_reg;
  assign PULSE_VALID  = pv_reg;
  assign OC_ENABLE    = oc_reg;
  assign OC_FLAG      = ocf_reg;

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  sequence s_acc_write_freq;
    REG_WR && REG_ADDR == MAC_ADDR_ACCUM && REG_WDATA[MAC_ACC_FREQ_BIT];
  endsequence
  sequence s_sample(mac_wire_t c);
    SAMPLE_VALID && wire_sel == c;
  endsequence

  property p_rule1;
    PWR_VALID && psel_reg[11:9] == 3'b100 && watt_mode == MAC_ACC_SIGNED
      && !PWR_REACTIVE[3] |=> signed'(PULSE_SUM[3*SW +: SW])
      == $past(signed'({{3{PWR_IN[12*PW-1]}}, PWR_IN[11*PW +: PW]}));
  endproperty
  a_rule1: assert property (p_rule1) else $error("pulse4 phase C sum wrong"); // [RULE1]
  property p_rule2;
    $past(SRST) |-> psel_reg == 12'h000 && !PULSE_VALID;
  endproperty
  a_rule2: assert property (p_rule2) else $error("include fields not reset"); // [RULE2]
  property p_rule3;
    s_acc_write_freq |=> ##1 LINE_IS_60HZ;
  endproperty
  a_rule3: assert property (p_rule3) else $error("60 Hz not selected"); // [RULE3]
  property p_rule4;
    !ZX_PRESENT && !acc_reg[MAC_ACC_FREQ_BIT] |=> LINE_PERIOD == PER_50;
  endproperty
  a_rule4: assert property (p_rule4) else $error("default period wrong"); // [RULE4]
  property p_rule5;
    SAMPLE_VALID && acc_reg[MAC_ACC_ICONS_BIT]
      |=> IB_EFF == $past(-(ei_a + ei_c)) && EFF_VALID;
  endproperty
  a_rule5: assert property (p_rule5) else $error("derived IB wrong"); // [RULE5]
  property p_rule6;
    s_sample(MAC_WIRE_NB_WYE) |=> VB_EFF == $past(-(ea + ec));
  endproperty
  a_rule6: assert property (p_rule6) else $error("non-Blondel wye VB wrong"); // [RULE6]
  property p_rule7;
    s_sample(MAC_WIRE_DELTA3) |=> VA_EFF == $past(ea - eb)
      && VC_EFF == $past(ec - eb);
  endproperty
  a_rule7: assert property (p_rule7) else $error("3-wire delta wrong"); // [RULE7]
  property p_rule8;
    s_sample(MAC_WIRE_DELTA_VB) |=> VB_EFF == $past(ea - ec)
      && VA_EFF == $past(ea);
  endproperty
  a_rule8: assert property (p_rule8) else $error("delta VB-only wrong"); // [RULE8]
  property p_rule9;
    PWR_VALID && psel_reg[2:0] == 3'b111 && var_mode == MAC_ACC_ABS
      && PWR_REACTIVE[0] |=> !PULSE_SUM[SW-1];
  endproperty
  a_rule9: assert property (p_rule9) else $error("abs reactive sum negative"); // [RULE9]
  property p_rule11;
    $past(SRST) |-> OC_ENABLE == 4'hf;
  endproperty
  a_rule11: assert property (p_rule11) else $error("OC enable reset wrong"); // [RULE11]
  property p_rule12;
    OC_FLAG[0] |-> $past(OC_RAW[0] && oc_reg[0]);
  endproperty
  a_rule12: assert property (p_rule12) else $error("phase A OC gating wrong"); // [RULE12]

endmodule
`default_nettype wire

/* File: rtl/mac_pkg.sv */
// Constants and types for the metering accumulation configuration registers
package mac_pkg;
  // Register offsets, as seen on the host register port
  localparam logic [11:0] MAC_ADDR_PULSE_SEL = 12'h491;
  localparam logic [11:0] MAC_ADDR_ACCUM     = 12'h492;
  localparam logic [11:0] MAC_ADDR_OC        = 12'h493;
  // Field positions and widths
  localparam int MAC_PSEL_FIELD_W  = 3;   // One include field per pulse output
  localparam int MAC_PSEL_W        = 12;  // Four fields, bits [11:0]
  localparam int MAC_ACC_W         = 9;   // Bits [8:0]; [15:9] reserved
  localparam int MAC_ACC_FREQ_BIT  = 8;
  localparam int MAC_ACC_ICONS_BIT = 7;
  localparam int MAC_ACC_WIRE_LSB  = 4;
  localparam int MAC_ACC_VAR_LSB   = 2;
  localparam int MAC_ACC_WATT_LSB  = 0;
  localparam int MAC_OC_LSB        = 12;  // Bits [15:12]
  localparam int MAC_OC_W          = 4;
  // Reset values
  localparam logic [MAC_PSEL_W-1:0] MAC_PSEL_RST = 12'h000;
  localparam logic [MAC_ACC_W-1:0]  MAC_ACC_RST  = 9'h000;
  localparam logic [MAC_OC_W-1:0]   MAC_OC_RST   = 4'hf;
  // Line frequency choices and the sample rate of the period counts
  localparam int MAC_LINE_HZ_50     = 50;
  localparam int MAC_LINE_HZ_60     = 60;
  localparam int MAC_SAMPLE_RATE_HZ = 8000;
  // Voltage wiring arrangements
  typedef enum logic [2:0] {
    MAC_WIRE_WYE      = 3'h0,
    MAC_WIRE_DELTA_VB = 3'h1,
    MAC_WIRE_NB_WYE   = 3'h2,
    MAC_WIRE_NB_DELTA = 3'h3,
    MAC_WIRE_DELTA3   = 3'h4
  } mac_wire_t;
  // Energy accumulation modes
  typedef enum logic [1:0] {
    MAC_ACC_SIGNED = 2'h0,
    MAC_ACC_ABS    = 2'h1,
    MAC_ACC_POS    = 2'h2,
    MAC_ACC_NEG    = 2'h3
  } mac_acc_t;
endpackage
